/* File: pmc_regs.svh */
/*
 power mode control: register offsets, field positions, reset values, timing counts.
 assumes inclusion by bare name from the warm-up divider and the mode controller.
*/
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_STOP_CTRL_OFF 8'h38
`define PMC_IDLE_CTRL_OFF 8'h39
`define PMC_STOP_BIT 7
`define PMC_STOP_RELEASE_METHOD_BIT 6
`define PMC_HOLD_BIT 4
`define PMC_WUT_HI 3
`define PMC_WUT_LO 2
`define PMC_XEN_BIT 7
`define PMC_IDLE_BIT 4
`define PMC_TGH_BIT 2
`define PMC_STOP_CTRL_RST 8'h00
`define PMC_IDLE_CTRL_RST 8'h80
`define PMC_WU_CODE00 18'h2FFFF
`define PMC_WU_CODE01 18'h0FFFF
`define PMC_WU_CODE10 18'h0BFFF
`define PMC_WU_CODE11 18'h03FFF
`endif

/* File: pmc_pkg.sv */
/*
 power mode control: types shared by the design files.
 assumes nothing beyond a SystemVerilog compiler.
*/
package pmc_pkg;
    typedef enum logic [2:0] {PMC_RUN, PMC_HALT, PMC_GATED, PMC_STOP, PMC_WARM} pmc_mode_t;
    typedef logic [17:0] pmc_cnt_t;
endpackage : pmc_pkg

/* File: pmc_warm_if.sv */
/*
 power mode control: carrier between mode controller and warm-up divider.
 assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface pmc_warm_if;
    import pmc_pkg::*;
    logic start;
    logic [1:0] sel;
    logic done;
    modport ctrl (output start, output sel, input done);
    modport div (input start, input sel, output done);
endinterface : pmc_warm_if
`default_nettype wire

/* File: pmc_warmup.sv */
/*
 power mode control: warm-up divider counting fc cycles.
 assumes start is a pulse; done pulses once the selected count is reached.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_warmup (
    input wire logic mclk,
    input wire logic rst_n,
    pmc_warm_if.div wi
);
    import pmc_pkg::*;
    pmc_cnt_t cnt_ff;
    pmc_cnt_t nxt_cnt;
    pmc_cnt_t limit;
    logic run_ff;
    logic nxt_run;
    logic done_ff;
    logic hit;
    // =========================================
    // warm-up count
    // selected warm-up length
    assign limit = (wi.sel == 2'h0) ? `PMC_WU_CODE00 :
                   (wi.sel == 2'h1) ? `PMC_WU_CODE01 :
                   (wi.sel == 2'h2) ? `PMC_WU_CODE10 : `PMC_WU_CODE11;
    assign hit = run_ff && (cnt_ff == limit);
    assign nxt_cnt = wi.start ? 18'h00000 : (run_ff ? cnt_ff + 18'h00001 : cnt_ff);
    assign nxt_run = wi.start | (run_ff & ~hit);
    assign wi.done = done_ff;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_ff <= 18'h00000;
            run_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            run_ff <= nxt_run;
            done_ff <= hit & ~wi.start;
        end
    end
endmodule : pmc_warmup
`default_nettype wire

/* File: pmc_edge.sv */
/*
 power mode control: falling edge detector for the time-base source clock.
 assumes the input is already synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_edge (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sig,
    output logic fall
);
    logic prev_ff;
    assign fall = prev_ff & ~sig;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sig;
        end
    end
endmodule : pmc_edge
`default_nettype wire

/* File: pmc_ctrl.sv */
/*
 power mode control: two control registers and the mode sequencer.
 assumes a single-cycle register port, synchronous pins, and rst_n from the reset pin.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_ctrl (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic stop_pin_in,
    input wire logic tb_src_clk,
    input wire logic irq_pending,
    output logic osc_on,
    output logic cpu_run,
    output logic wdt_run,
    output logic periph_clk_en,
    output logic port_out_en,
    output logic port_in_zero,
    output logic stop_pin_oe,
    output logic sw_reset_req,
    output pmc_pkg::pmc_mode_t mode
);
    import pmc_pkg::*;
    // =========================================
    // registers and decode
    logic [7:0] stop_ctl_ff;
    logic [7:0] idle_ctl_ff;
    pmc_mode_t mode_ff;
    pmc_mode_t nxt_mode;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic stop_pin_d_ff;
    logic tb_fall;
    logic wr_stop, wr_idle, rd_stop, rd_idle;
    logic stop_req, idle_req, gate_req;
    logic rel_edge, rel_level, stop_release;
    logic halt_exit, gated_exit;
    logic hold_sel, osc_off_req;
    logic osc_ff, cpu_ff, wdt_ff, pclk_ff, pout_ff, pin0_ff, spoe_ff, srst_ff;
    pmc_warm_if wif ();

    assign wr_stop = wr && (addr == `PMC_STOP_CTRL_OFF);
    assign wr_idle = wr && (addr == `PMC_IDLE_CTRL_OFF);
    assign rd_stop = rd && (addr == `PMC_STOP_CTRL_OFF);
    assign rd_idle = rd && (addr == `PMC_IDLE_CTRL_OFF);
    assign stop_req = wr_stop && wdata[`PMC_STOP_BIT] && (mode_ff == PMC_RUN);
    assign idle_req = wr_idle && wdata[`PMC_IDLE_BIT] && (mode_ff == PMC_RUN);
    assign gate_req = wr_idle && wdata[`PMC_TGH_BIT] && !wdata[`PMC_IDLE_BIT]
                      && (mode_ff == PMC_RUN);
    assign rel_edge = stop_pin_in && !stop_pin_d_ff;
    assign rel_level = stop_pin_in;
    assign stop_release = stop_ctl_ff[`PMC_STOP_RELEASE_METHOD_BIT] ? rel_level : rel_edge;
    assign halt_exit = (mode_ff == PMC_HALT) && irq_pending;
    assign gated_exit = (mode_ff == PMC_GATED) && tb_fall;
    // undefined low bits read as zero
    assign nxt_rdata = rd_stop ? {stop_ctl_ff[7:2], 2'h0} :
                       rd_idle ? {idle_ctl_ff[7:4], 1'b0, idle_ctl_ff[2], 2'h0} : 8'h00;
    assign wif.sel = stop_ctl_ff[`PMC_WUT_HI:`PMC_WUT_LO];
    // hold bit as it stands after this edge
    // the stop write may change it, so entry must not use the old copy
    assign hold_sel = wr_stop ? wdata[`PMC_HOLD_BIT] : stop_ctl_ff[`PMC_HOLD_BIT];
    // oscillator enable cleared by a write
    assign osc_off_req = wr_idle && !wdata[`PMC_XEN_BIT];
    // level release with pin high warms at once
    assign wif.start = (mode_ff == PMC_STOP && stop_release)
                       || (stop_req && wdata[`PMC_STOP_RELEASE_METHOD_BIT] && stop_pin_in);

    pmc_warmup u_warm (
        .mclk(mclk),
        .rst_n(rst_n),
        .wi(wif)
    );
    // edge taken from time-base clock, already synchronous to mclk
    pmc_edge u_tb (
        .mclk(mclk),
        .rst_n(rst_n),
        .sig(tb_src_clk),
        .fall(tb_fall)
    );

    // =========================================
    // mode sequencer
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            PMC_RUN: begin
                if (stop_req) begin
                    // release method rides on the same write as the stop bit
                    nxt_mode = (wdata[`PMC_STOP_RELEASE_METHOD_BIT] && stop_pin_in) ? PMC_WARM : PMC_STOP;
                end else if (idle_req) begin
                    nxt_mode = PMC_HALT;
                end else if (gate_req) begin
                    nxt_mode = PMC_GATED;
                end
            end
            PMC_HALT: if (halt_exit) nxt_mode = PMC_RUN;
            PMC_GATED: if (gated_exit) nxt_mode = PMC_RUN;
            PMC_STOP: if (stop_release) nxt_mode = PMC_WARM;
            PMC_WARM: if (wif.done) nxt_mode = PMC_RUN;
            default: nxt_mode = PMC_RUN;
        endcase
    end

    // =========================================
    // register file
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stop_ctl_ff <= `PMC_STOP_CTRL_RST;
            idle_ctl_ff <= `PMC_IDLE_CTRL_RST;
            mode_ff <= PMC_RUN;
            rdata_ff <= 8'h00;
            stop_pin_d_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            rdata_ff <= nxt_rdata;
            stop_pin_d_ff <= stop_pin_in;
            if (wr_stop) begin
                stop_ctl_ff <= {wdata[7:6], 1'b0, wdata[4:2], 2'h0};
            end else if (mode_ff == PMC_WARM && wif.done) begin
                stop_ctl_ff[`PMC_STOP_BIT] <= 1'b0;
            end
            if (wr_idle) begin
                // bits 6, 5 stored as zero
                // both set counts as halt only
                idle_ctl_ff <= {wdata[7], 2'h0, wdata[4], 1'b0,
                                wdata[2] & ~wdata[4], 2'h0};
            end else begin
                if (halt_exit) idle_ctl_ff[`PMC_IDLE_BIT] <= 1'b0;
                if (gated_exit) idle_ctl_ff[`PMC_TGH_BIT] <= 1'b0;
            end
        end
    end

    // =========================================
    // registered outputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            osc_ff <= 1'b1;
            cpu_ff <= 1'b1;
            wdt_ff <= 1'b1;
            pclk_ff <= 1'b1;
            pout_ff <= 1'b1;
            pin0_ff <= 1'b0;
            spoe_ff <= 1'b1;
            srst_ff <= 1'b0;
        end else begin
            // also off for the software reset pulse
            osc_ff <= (nxt_mode != PMC_STOP) && !osc_off_req;
            cpu_ff <= (nxt_mode == PMC_RUN);
            wdt_ff <= (nxt_mode == PMC_RUN);
            pclk_ff <= (nxt_mode == PMC_RUN) || (nxt_mode == PMC_HALT);
            pout_ff <= !(nxt_mode == PMC_STOP || nxt_mode == PMC_WARM)
                       || hold_sel;
            pin0_ff <= (nxt_mode == PMC_STOP || nxt_mode == PMC_WARM)
                       && !hold_sel;
            spoe_ff <= !(nxt_mode == PMC_STOP || nxt_mode == PMC_WARM);
            srst_ff <= osc_off_req;
        end
    end

    assign rdata = rdata_ff;
    assign osc_on = osc_ff;
    assign cpu_run = cpu_ff;
    assign wdt_run = wdt_ff;
    assign periph_clk_en = pclk_ff;
    assign port_out_en = pout_ff;
    assign port_in_zero = pin0_ff;
    assign stop_pin_oe = spoe_ff;
    assign sw_reset_req = srst_ff;
    assign mode = mode_ff;

    // =========================================
    // assertions
    // idle clears on release
    idle_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        halt_exit && !wr_idle |=> !idle_ctl_ff[`PMC_IDLE_BIT]) else $error("idle bit kept");
    gate_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        gated_exit && !wr_idle |=> !idle_ctl_ff[`PMC_TGH_BIT]) else $error("gate bit kept");
    stop_osc_a: assert property (@(posedge mclk) disable iff (!rst_n)
        stop_req && !stop_pin_in |=> mode_ff == PMC_STOP ##1 !osc_on) else $error("osc on");
    stop_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_ff == PMC_STOP |-> ##1 !stop_pin_oe || mode_ff != PMC_STOP) else $error("pin driven");
    level_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
        stop_req && wdata[`PMC_STOP_RELEASE_METHOD_BIT] && stop_pin_in |=> mode_ff == PMC_WARM)
        else $error("stop entered with pin high");
    warm_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_ff == PMC_WARM && $past(mode_ff) == PMC_WARM |-> !cpu_run) else $error("cpu ran");
    read_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_stop |=> rdata[1:0] == 2'h0) else $error("low bits");
    osc_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_idle && !wdata[`PMC_XEN_BIT] |=> sw_reset_req && !osc_on) else $error("no reset");
    gated_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
        gated_exit |=> mode_ff == PMC_RUN ##1 periph_clk_en) else $error("gating held");
    stop_cov_c: cover property (@(posedge mclk) mode_ff == PMC_STOP ##[1:50] mode_ff == PMC_WARM);
    halt_cov_c: cover property (@(posedge mclk) halt_exit);
    gate_cov_c: cover property (@(posedge mclk) gated_exit);
    stop_halt_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_ff == PMC_STOP |-> !osc_on && !cpu_run && !periph_clk_en)
        else $error("stop not halting");
    hold_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode_ff == PMC_STOP || mode_ff == PMC_WARM) && stop_ctl_ff[`PMC_HOLD_BIT]
        |-> port_out_en && !port_in_zero) else $error("ports floated");
    float_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode_ff == PMC_STOP || mode_ff == PMC_WARM) && !stop_ctl_ff[`PMC_HOLD_BIT]
        |-> !port_out_en && port_in_zero) else $error("inputs not zeroed");
    halt_run_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_ff == PMC_HALT |-> !cpu_run && !wdt_run && periph_clk_en)
        else $error("halt outputs");
    gated_clk_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_ff == PMC_GATED |-> !periph_clk_en && !cpu_run) else $error("gated outputs");
    halt_wake_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_ff == PMC_HALT && irq_pending |=> mode_ff == PMC_RUN ##1 cpu_run)
        else $error("halt held");
    read_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_idle |=> rdata[3] == 1'b0 && rdata[1:0] == 2'h0) else $error("idle low bits");
    gate_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_idle && wdata[`PMC_IDLE_BIT] |=> !idle_ctl_ff[`PMC_TGH_BIT]) else $error("both set");
    warm_osc_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_ff == PMC_WARM |-> osc_on && !stop_pin_oe) else $error("warm-up osc");
    reset_run_a: assert property (@(posedge mclk)
        !rst_n |=> mode_ff == PMC_RUN && cpu_run && osc_on) else $error("reset mode");
    level_skip_c: cover property (@(posedge mclk) stop_req && wdata[`PMC_STOP_RELEASE_METHOD_BIT] && stop_pin_in);
    sw_reset_c: cover property (@(posedge mclk) sw_reset_req);
endmodule : pmc_ctrl
`default_nettype wire

/* File: pmc_far_model.sv */
/*
 far side model: shared stop pin, time-base source clock, interrupt request.
 assumes the bench calls its tasks; all pins change just after a rising mclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_far_model (
    input wire logic mclk,
    output logic stop_pin,
    output logic tb_clk,
    output logic irq
);
    // ==========================================
    // pin drivers
    initial begin
        stop_pin = 1'b0;
        tb_clk = 1'b1;
        irq = 1'b0;
    end
    // level or edge on the stop pin
    task automatic set_pin(input logic v);
        @(posedge mclk);
        stop_pin <= v;
    endtask : set_pin
    // one falling edge, held low long enough for the detector
    task automatic tb_fall();
        @(posedge mclk);
        tb_clk <= 1'b0;
        repeat (4) @(posedge mclk);
        tb_clk <= 1'b1;
    endtask : tb_fall
    task automatic irq_req();
        @(posedge mclk);
        irq <= 1'b1;
        repeat (3) @(posedge mclk);
        irq <= 1'b0;
    endtask : irq_req
endmodule : pmc_far_model
`default_nettype wire

/* File: power_mode_control_test.sv */
/*
 self-checking bench for the power mode controller with a register image model.
 assumes pmc_ctrl as top, pmc_far_model as far side, fixed warm-up counts.
*/
`timescale 1ns/1ps
`default_nettype none
module power_mode_control_test;
    import pmc_pkg::*;
    logic mclk, rst_n, wr, rd, stop_pin, tb_clk, irq;
    logic [7:0] addr, wdata, rdata, d;
    logic osc_on, cpu_run, wdt_run, periph_clk_en, port_out_en, port_in_zero;
    logic stop_pin_oe, sw_reset_req;
    pmc_mode_t mode;
    int fail_count, compares, seed, n, i;
    int mreg[2];
    pmc_ctrl pmc_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .stop_pin_in(stop_pin), .tb_src_clk(tb_clk),
        .irq_pending(irq), .osc_on(osc_on), .cpu_run(cpu_run), .wdt_run(wdt_run),
        .periph_clk_en(periph_clk_en), .port_out_en(port_out_en),
        .port_in_zero(port_in_zero), .stop_pin_oe(stop_pin_oe),
        .sw_reset_req(sw_reset_req), .mode(mode));
    pmc_far_model pmc_far_model_inst (.mclk(mclk), .stop_pin(stop_pin), .tb_clk(tb_clk),
        .irq(irq));
    // ==========================================
    // clock, watchdog, verdict
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        #450000;
        fail_count++;
        tally_and_finish();
    end
    task automatic tally_and_finish();
        if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    // ==========================================
    // compares and bus cycles
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_mode(input pmc_mode_t m);
        compares++;
        if (mode !== m) begin
            fail_count++;
            $display("ERROR %0t mode %0d expected %0d", $time, mode, m);
        end
    endtask : chk_mode
    function automatic logic [7:0] outs();
        return {osc_on, cpu_run, wdt_run, periph_clk_en, port_out_en, port_in_zero,
            stop_pin_oe, sw_reset_req};
    endfunction : outs
    // image of what reads return once any mode has finished
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        // look at outputs only once the edge has settled
        #1;
        if (a == 8'h38) mreg[0] = v & 8'h5C;
        if (a == 8'h39) mreg[1] = v & 8'h80;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk_val(rdata, (a == 8'h38) ? mreg[0] : (a == 8'h39) ? mreg[1] : 8'h00);
    endtask : rd_chk
    task automatic wait_mode(input pmc_mode_t m, input int lim);
        n = 0;
        while (mode !== m && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk_mode(m);
    endtask : wait_mode
    task automatic go_reset();
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        mreg[0] = 8'h00;
        mreg[1] = 8'h80;
        @(posedge mclk);
        #1;
    endtask : go_reset
    // model warm-up length in fc cycles
    function automatic int wu(input int c);
        return (c == 0) ? 3 * 2 ** 16 : (c == 1) ? 2 ** 16 : (c == 2) ? 3 * 2 ** 14 : 2 ** 14;
    endfunction : wu
    task automatic stop_run(input logic [7:0] v, input logic [7:0] exp_st);
        wr_reg(8'h38, v);
        wait_mode(PMC_STOP, 4);
        repeat (2) @(posedge mclk);
        #1;
        chk_val(outs(), exp_st);
        pmc_far_model_inst.set_pin(1'b1);
        wait_mode(PMC_WARM, 6);
        wait_mode(PMC_RUN, wu(v[3:2]) + 8);
        chk_val({7'h00, n >= wu(v[3:2]) - 1 && n <= wu(v[3:2]) + 2}, 8'h01);
        pmc_far_model_inst.set_pin(1'b0);
        rd_chk(8'h38);
    endtask : stop_run
    // ==========================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        fail_count = 0;
        compares = 0;
        seed = 32'h39FE9455;
        go_reset();
        chk_val(outs(), 8'hFA);
        rd_chk(8'h38);
        rd_chk(8'h39);
        // software keeps reserved bits zero; undefined bits read zero
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            wr_reg(8'h38, d & 8'h5F);
            rd_chk(8'h38);
            wr_reg(8'h39, (d | 8'h80) & 8'h8B);
            rd_chk(8'h39);
            wr_reg(8'h40, d);
            rd_chk(8'h40);
        end
        wr_reg(8'h38, 8'h00);
        wr_reg(8'h39, 8'h90);
        wait_mode(PMC_HALT, 4);
        repeat (2) @(posedge mclk);
        #1;
        chk_val(outs(), 8'h9A);
        pmc_far_model_inst.irq_req();
        wait_mode(PMC_RUN, 8);
        rd_chk(8'h39);
        wr_reg(8'h39, 8'h84);
        wait_mode(PMC_GATED, 4);
        repeat (2) @(posedge mclk);
        #1;
        chk_val(outs(), 8'h8A);
        pmc_far_model_inst.tb_fall();
        wait_mode(PMC_RUN, 8);
        rd_chk(8'h39);
        // both bits at once: gate dropped, halt taken
        wr_reg(8'h39, 8'h94);
        wait_mode(PMC_HALT, 4);
        pmc_far_model_inst.irq_req();
        wait_mode(PMC_RUN, 8);
        rd_chk(8'h39);
        // edge release, ports floated, shortest warm-up
        stop_run(8'h8C, 8'h04);
        // level release with pin already high skips stop
        pmc_far_model_inst.set_pin(1'b1);
        wr_reg(8'h38, 8'hD8);
        wait_mode(PMC_WARM, 3);
        chk_val({7'h00, n == 0}, 8'h01);
        chk_val(outs(), 8'h88);
        repeat (2) @(posedge mclk);
        #1;
        chk_val(outs(), 8'h88);
        wait_mode(PMC_RUN, wu(2) + 8);
        chk_val({7'h00, n >= wu(2) - 4 && n <= wu(2) + 2}, 8'h01);
        pmc_far_model_inst.set_pin(1'b0);
        rd_chk(8'h38);
        wr_reg(8'h38, 8'h8C);
        wait_mode(PMC_STOP, 4);
        go_reset();
        chk_mode(PMC_RUN);
        chk_val(outs(), 8'hFA);
        rd_chk(8'h38);
        // clearing oscillator enable requests a device reset
        wr_reg(8'h39, 8'h00);
        n = 0;
        while (sw_reset_req !== 1'b1 && n < 4) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk_val({6'h00, sw_reset_req, osc_on}, 8'h02);
        go_reset();
        tally_and_finish();
    end
endmodule : power_mode_control_test
`default_nettype wire
